// ==== verilog/ramp_adc_ctrl.sv ====
// PWM fault shutdown and single-slope ramp converter timing
// Assumes analog comparators and fault pin are asynchronous to mclk.
`timescale 1ns/1ns
module ramp_adc_ctrl
  import ramp_adc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Register port
  input wire logic [15:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // Fault pin, active low
  input wire logic fault_trip_in_n,
  // Comparators: main 1..3 then auxiliary
  input wire logic [3:0] compTrip,
  // Analog controls
  output logic [1:0] auxSelect,
  output logic [2:0] ramp_current_trim,
  output logic rampReset,
  // PWM
  output logic [5:0] pwmOut,
  output logic cycle_sync_pulse,
  output logic irq
);
  typedef enum {ST_HALT, ST_ARMED, ST_RUN} run_state_t;
  run_state_t state_reg;

  logic faultSync;
  logic [3:0] compSync;
  logic [11:0] timerCount;
  logic timerSat;
  logic [15:0] mode_reg, period_reg, syncWidth_reg;
  logic [15:0] dutyA_reg, dutyB_reg, dutyC_reg;
  logic [15:0] dutyLatA_reg, dutyLatB_reg, dutyLatC_reg;
  logic [2:0] trim_reg;
  logic softShut_reg, softCause_reg, shutLatch_reg;
  logic [3:0] initDone_reg;
  logic [15:0] pwmCnt_reg, syncCnt_reg;
  logic syncActive_reg, syncRise;
  logic [11:0] result_reg [NUM_CHANNELS];
  logic [NUM_CHANNELS-1:0] captured_reg;
  logic [1:0] irqStatus_reg, irqMask_reg;
  logic [5:0] pwmRaw_reg;
  logic shutdown, wrHit, rdSoft, restartOk;

  sync_stage faultSyncer (
    .mclk(mclk),
    .clkEn(clkEn),
    .asyncIn(fault_trip_in_n),
    .syncOut(faultSync)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : gen_comp
      sync_stage compSyncer (
        .mclk(mclk),
        .clkEn(clkEn),
        .asyncIn(compTrip[g]),
        .syncOut(compSync[g])
      );
    end
  endgenerate

  ramp_timer timer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .restart(syncRise),
    .fullRate(mode_reg[RATE_SEL_BIT]),
    .count(timerCount),
    .saturated(timerSat)
  );

  assign wrHit = regWr && regAddr == ADDR_SOFT_SHUTDOWN;
  assign rdSoft = regRd && regAddr == ADDR_SOFT_SHUTDOWN;
  // Latched or software shutdown, plus the pin after the two-flop synchroniser
  assign shutdown = shutLatch_reg || softShut_reg || !faultSync;
  // Pin high, all four timing registers rewritten and software cause read back
  assign restartOk = state_reg == ST_HALT && &initDone_reg && faultSync && !softShut_reg;

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
      period_reg <= PERIOD_RESET;
      dutyA_reg <= 16'h0000;
      dutyB_reg <= 16'h0000;
      dutyC_reg <= 16'h0000;
      syncWidth_reg <= SYNC_WIDTH_RESET;
      trim_reg <= TRIM_RESET;
      irqMask_reg <= 2'b00;
    end else if (clkEn && regWr) begin
      if (regAddr == ADDR_MODE_CONTROL) begin
        mode_reg <= regWrData;
      end else if (regAddr == ADDR_PWM_PERIOD) begin
        period_reg <= regWrData;
      end else if (regAddr == ADDR_DUTY_A) begin
        dutyA_reg <= regWrData;
      end else if (regAddr == ADDR_DUTY_B) begin
        dutyB_reg <= regWrData;
      end else if (regAddr == ADDR_DUTY_C) begin
        dutyC_reg <= regWrData;
      end else if (regAddr == ADDR_SYNC_WIDTH) begin
        syncWidth_reg <= regWrData;
      end else if (regAddr == ADDR_TRIM) begin
        trim_reg <= regWrData[2:0];
      end else if (regAddr == ADDR_IRQ_MASK) begin
        irqMask_reg <= regWrData[1:0];
      end
    end
  end

  // Shutdown cause; the read-clear loses to a new write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      softShut_reg <= 1'b0;
      softCause_reg <= 1'b0;
      shutLatch_reg <= 1'b0;
    end else if (clkEn) begin
      if (wrHit) begin
        softShut_reg <= 1'b1;
        softCause_reg <= 1'b1;
      end else if (rdSoft) begin
        softShut_reg <= 1'b0;
        softCause_reg <= 1'b0;
      end
      if (!faultSync || wrHit) begin
        shutLatch_reg <= 1'b1;
      end else if (restartOk) begin
        // Held until restart, so RUN never re-trips on a stale latch
        shutLatch_reg <= 1'b0;
      end
    end
  end

  // Restart sequencing after shutdown
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_reg <= ST_ARMED;
      initDone_reg <= 4'hF;
    end else if (clkEn) begin
      case (state_reg)
        ST_RUN: begin
          if (shutdown) begin
            state_reg <= ST_HALT;
            initDone_reg <= 4'h0;
          end
        end
        ST_HALT: begin
          if (regWr && regAddr == ADDR_PWM_PERIOD) initDone_reg[0] <= 1'b1;
          if (regWr && regAddr == ADDR_DUTY_A) initDone_reg[1] <= 1'b1;
          if (regWr && regAddr == ADDR_DUTY_B) initDone_reg[2] <= 1'b1;
          if (regWr && regAddr == ADDR_DUTY_C) initDone_reg[3] <= 1'b1;
          // Writes made while the pin is still low do not count
          if (!faultSync) begin
            initDone_reg <= 4'h0;
          end
          if (restartOk) begin
            state_reg <= ST_ARMED;
          end
        end
        default: begin
          if (!faultSync || wrHit) begin
            state_reg <= ST_HALT;
            initDone_reg <= 4'h0;
          end else begin
            state_reg <= ST_RUN;
          end
        end
      endcase
    end
  end

  // PWM counter and sync pulse timing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwmCnt_reg <= 16'h0000;
      syncCnt_reg <= 16'h0000;
      syncActive_reg <= 1'b0;
    end else if (clkEn) begin
      if (state_reg == ST_HALT) begin
        pwmCnt_reg <= 16'h0000;
        syncCnt_reg <= 16'h0000;
        syncActive_reg <= 1'b0;
      end else if (pwmCnt_reg >= period_reg) begin
        pwmCnt_reg <= 16'h0000;
        syncActive_reg <= 1'b1;
        syncCnt_reg <= syncWidth_reg;
      end else begin
        pwmCnt_reg <= pwmCnt_reg + 16'h0001;
        if (syncCnt_reg > 16'h0001) begin
          syncCnt_reg <= syncCnt_reg - 16'h0001;
        end else begin
          syncActive_reg <= 1'b0;
        end
      end
    end
  end

  assign syncRise = clkEn && state_reg != ST_HALT && pwmCnt_reg >= period_reg;

  // Duties latch on the sync rising edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dutyLatA_reg <= 16'h0000;
      dutyLatB_reg <= 16'h0000;
      dutyLatC_reg <= 16'h0000;
    end else if (syncRise) begin
      dutyLatA_reg <= dutyA_reg;
      dutyLatB_reg <= dutyB_reg;
      dutyLatC_reg <= dutyC_reg;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pwmRaw_reg <= 6'b00_0000;
    end else if (clkEn) begin
      pwmRaw_reg[0] <= pwmCnt_reg < dutyLatA_reg;
      pwmRaw_reg[1] <= !(pwmCnt_reg < dutyLatA_reg);
      pwmRaw_reg[2] <= pwmCnt_reg < dutyLatB_reg;
      pwmRaw_reg[3] <= !(pwmCnt_reg < dutyLatB_reg);
      pwmRaw_reg[4] <= pwmCnt_reg < dutyLatC_reg;
      pwmRaw_reg[5] <= !(pwmCnt_reg < dutyLatC_reg);
    end
  end

  // Raw pin gates outputs combinationally, so a trip needs no clock
  assign pwmOut = (fault_trip_in_n && !shutdown) ? pwmRaw_reg : 6'b00_0000;
  assign cycle_sync_pulse = syncActive_reg && fault_trip_in_n && !shutdown;
  assign rampReset = cycle_sync_pulse;

  // Per-channel capture of first trip
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : gen_result
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          result_reg[g] <= RESULT_NONE;
          captured_reg[g] <= 1'b0;
        end else if (clkEn) begin
          if (syncRise) begin
            captured_reg[g] <= 1'b0;
            if (!captured_reg[g]) begin
              result_reg[g] <= RESULT_NONE;
            end
          end else if (compSync[g] && !captured_reg[g] && !syncActive_reg) begin
            result_reg[g] <= timerCount;
            captured_reg[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Sticky interrupts; a new event beats the write-one clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irqStatus_reg <= 2'b00;
    end else if (clkEn) begin
      irqStatus_reg <= (irqStatus_reg & ~((regWr && regAddr == ADDR_IRQ_STATUS) ? regWrData[1:0] : 2'b00))
        | {shutdown, syncRise && !shutdown};
    end
  end

  assign irq = |(irqStatus_reg & irqMask_reg);
  assign auxSelect = mode_reg[AUX_SEL_LSB +: 2];
  assign ramp_current_trim = trim_reg;

  // Read port
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      regRdData <= 16'h0000;
    end else if (clkEn) begin
      regRdData <= 16'h0000;
      if (regRd) begin
        if (regAddr == ADDR_SOFT_SHUTDOWN) begin
          regRdData <= {15'h0000, softCause_reg};
        end else if (regAddr == ADDR_SYS_STATUS) begin
          regRdData <= {15'h0000, faultSync};
        end else if (regAddr == ADDR_MODE_CONTROL) begin
          regRdData <= mode_reg;
        end else if (regAddr == ADDR_PWM_PERIOD) begin
          regRdData <= period_reg;
        end else if (regAddr == ADDR_SYNC_WIDTH) begin
          regRdData <= syncWidth_reg;
        end else if (regAddr == ADDR_TRIM) begin
          regRdData <= {13'h0000, trim_reg};
        end else if (regAddr[15:2] == ADDR_RESULT_BASE[15:2]) begin
          regRdData <= {4'h0, result_reg[regAddr[1:0]]};
        end else if (regAddr == ADDR_IRQ_STATUS) begin
          regRdData <= {14'h0000, irqStatus_reg};
        end else if (regAddr == ADDR_IRQ_MASK) begin
          regRdData <= {14'h0000, irqMask_reg};
        end
      end
    end
  end

  a_fault_blocks_pwm: assert property (@(posedge mclk) disable iff (sys_rst)
    !fault_trip_in_n |-> pwmOut == 6'b00_0000 && !cycle_sync_pulse)
    else $error("PWM active during fault");
  a_soft_write_stops: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && wrHit |=> pwmOut == 6'b00_0000 && softCause_reg)
    else $error("Soft shutdown did not stop PWM");
  a_soft_read_clears: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && rdSoft && !wrHit |=> !softCause_reg)
    else $error("Shutdown cause not cleared by read");
  a_status_fault: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && regRd && regAddr == ADDR_SYS_STATUS |=> regRdData[0] == $past(faultSync))
    else $error("Status bit does not show fault level");
  a_aux_select: assert property (@(posedge mclk) disable iff (sys_rst)
    clkEn && regWr && regAddr == ADDR_MODE_CONTROL |=> auxSelect == $past(regWrData[1:0]))
    else $error("Aux select mismatch");
  a_timer_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    syncRise |=> timerCount == 12'h000)
    else $error("Timer not restarted at sync");
  a_result_bound: assert property (@(posedge mclk) disable iff (sys_rst)
    timerSat && !syncRise |=> timerCount == COUNT_MAX)
    else $error("Timer passed 4095");
  a_halt_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    state_reg == ST_HALT && !(&initDone_reg) |=> state_reg == ST_HALT)
    else $error("Restart before initialisation");
  a_no_trip_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    syncRise && !captured_reg[0] |=> result_reg[0] == RESULT_NONE)
    else $error("Missing trip not zero");
endmodule

// ==== verilog/ramp_adc_pkg.sv ====
// Package: register offsets, fields, reset values and timing counts
// Assumes a 50 MHz mclk and a word-per-offset register port.
package ramp_adc_pkg;
  localparam logic [15:0] ADDR_SOFT_SHUTDOWN = 16'h2061;
  localparam logic [15:0] ADDR_SYS_STATUS = 16'h2062;
  localparam logic [15:0] ADDR_MODE_CONTROL = 16'h2063;
  localparam logic [15:0] ADDR_PWM_PERIOD = 16'h2064;
  localparam logic [15:0] ADDR_DUTY_A = 16'h2065;
  localparam logic [15:0] ADDR_DUTY_B = 16'h2066;
  localparam logic [15:0] ADDR_DUTY_C = 16'h2067;
  localparam logic [15:0] ADDR_SYNC_WIDTH = 16'h2068;
  localparam logic [15:0] ADDR_TRIM = 16'h2069;
  localparam logic [15:0] ADDR_RESULT_BASE = 16'h2070;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h2074;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h2075;
  localparam int FAULT_BIT = 0;
  localparam int AUX_SEL_LSB = 0;
  localparam int RATE_SEL_BIT = 7;
  localparam int IRQ_SYNC_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [15:0] SYNC_WIDTH_RESET = 16'h0001;
  localparam logic [2:0] TRIM_RESET = 3'h0;
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  localparam logic [11:0] RESULT_NONE = 12'h000;
  localparam int NUM_CHANNELS = 4;
endpackage

// ==== verilog/sync_stage.sv ====
// Two-flop synchroniser for one level from another domain
// Assumes the input is quasi-static relative to mclk.
`timescale 1ns/1ns
module sync_stage
  import ramp_adc_pkg::*;
(
  // Clock
  input wire logic mclk,
  input wire logic clkEn,
  // Data
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_reg;

  always_ff @(posedge mclk) begin
    if (clkEn) begin
      meta_reg <= asyncIn;
      syncOut <= meta_reg;
    end
  end
endmodule

// ==== verilog/ramp_timer.sv ====
// Shared 12-bit conversion timer, restarted by the sync pulse
// Assumes restart and rate select come from mclk logic.
`timescale 1ns/1ns
module ramp_timer
  import ramp_adc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Control
  input wire logic restart,
  input wire logic fullRate,
  // Count
  output logic [11:0] count,
  output logic saturated
);
  logic halfPhase_reg;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count <= 12'h000;
      halfPhase_reg <= 1'b0;
    end else if (clkEn) begin
      if (restart) begin
        count <= 12'h000;
        halfPhase_reg <= 1'b0;
      end else begin
        halfPhase_reg <= ~halfPhase_reg;
        // Saturate so counts never pass 4095
        if ((fullRate || halfPhase_reg) && count != COUNT_MAX) begin
          count <= count + 12'h001;
        end
      end
    end
  end

  assign saturated = (count == COUNT_MAX);
endmodule

// ==== sim/fault_ramp_front.sv ====
// Model of the far side: fault sensor and four ramp comparators
// Assumes rampReset mirrors the block's sync pulse on the same mclk.
`timescale 1ns/1ns
module fault_ramp_front (
  // Clock
  input wire logic mclk,
  // Bench commands, delay in mclk cycles per channel, zero never trips
  input wire logic faultActive,
  input wire logic [31:0] tripDelay,
  // Block side
  input wire logic rampReset,
  output logic fault_trip_in_n,
  output logic [3:0] compTrip
);
  logic [11:0] rampCount;
  // Driven at all times, so the pull-down never decides the level
  assign fault_trip_in_n = !faultActive;
  initial begin
    rampCount = 12'h000;
    compTrip = 4'h0;
  end
  always @(posedge mclk) begin
    if (rampReset) begin
      rampCount <= 12'h000;
      compTrip <= 4'h0;
    end else begin
      if (rampCount != 12'hFFF) rampCount <= rampCount + 12'h001;
      for (int ch = 0; ch < 4; ch++) begin
        // Comparator stays tripped until the ramp is discharged
        if (tripDelay[ch*8 +: 8] != 8'h00 && rampCount == {4'h0, tripDelay[ch*8 +: 8]}) compTrip[ch] <= 1'b1;
      end
    end
  end
endmodule

// ==== sim/pwm_fault_and_ramp_adc_timing_tb.sv ====
// Self-checking bench for the fault shutdown and ramp converter timing
// Assumes the front end model beside it and a 50 MHz mclk.
`timescale 1ns/1ns
module pwm_fault_and_ramp_adc_timing_tb;
  import ramp_adc_pkg::*;
  logic mclk, sys_rst, clkEn, regWr, regRd, faultActive;
  logic [15:0] regAddr, regWrData, regRdData, rdVal;
  logic [31:0] tripDelay;
  logic fault_trip_in_n, rampReset, cycle_sync_pulse, irq;
  logic [3:0] compTrip;
  logic [1:0] auxSelect;
  logic [2:0] ramp_current_trim;
  logic [5:0] pwmOut;
  logic [15:0] res [4];
  int fail_count, num_checks, w;

  ramp_adc_ctrl i_ramp_adc_ctrl (.mclk(mclk), .sys_rst(sys_rst), .clkEn(clkEn), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .fault_trip_in_n(fault_trip_in_n), .compTrip(compTrip), .auxSelect(auxSelect),
    .ramp_current_trim(ramp_current_trim), .rampReset(rampReset), .pwmOut(pwmOut),
    .cycle_sync_pulse(cycle_sync_pulse), .irq(irq));
  fault_ramp_front i_fault_ramp_front (.mclk(mclk), .faultActive(faultActive), .tripDelay(tripDelay),
    .rampReset(rampReset), .fault_trip_in_n(fault_trip_in_n), .compTrip(compTrip));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rdVal = regRdData;
  endtask

  // Returns the number of cycles the next sync pulse stays high
  task automatic waitSync(output int width);
    int n;
    n = 0;
    width = 0;
    while (cycle_sync_pulse !== 1'b0 && n < 3000) begin @(negedge mclk); n++; end
    while (cycle_sync_pulse !== 1'b1 && n < 3000) begin @(negedge mclk); n++; end
    while (cycle_sync_pulse === 1'b1 && n < 3000) begin @(negedge mclk); n++; width++; end
    check(16'(n < 3000), 16'h0001);
  endtask

  task automatic waitPwm();
    int n;
    @(negedge mclk);
    for (n = 0; n < 1000 && pwmOut === 6'h00; n++) @(negedge mclk);
    check(16'(n < 1000), 16'h0001);
  endtask

  task automatic quiet();
    int bad;
    bad = 0;
    repeat (300) begin
      @(negedge mclk);
      if (cycle_sync_pulse !== 1'b0 || pwmOut !== 6'h00) bad++;
    end
    check(16'(bad), 16'h0000);
  endtask

  // Reads taken mid-cycle, after every trip and before the next sync
  task automatic readRes();
    waitSync(w);
    waitSync(w);
    repeat (80) @(negedge mclk);
    check({15'h0, rampReset}, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      rd(ADDR_RESULT_BASE + 16'(c));
      res[c] = rdVal;
    end
  endtask

  task automatic restart(input logic [15:0] cause);
    rd(ADDR_SOFT_SHUTDOWN);
    check(rdVal & 16'h0001, cause);
    rd(ADDR_SOFT_SHUTDOWN);
    check(rdVal & 16'h0001, 16'h0000);
    quiet();
    wr(ADDR_PWM_PERIOD, 16'h00C8);
    for (int i = 0; i < 3; i++) wr(ADDR_DUTY_A + 16'(i), 16'h0032);
    waitSync(w);
    waitPwm();
    wr(ADDR_IRQ_STATUS, 16'h0003);
    @(negedge mclk);
    check({15'h0, irq}, 16'h0000);
  endtask

  task automatic testReset();
    @(negedge mclk);
    check({10'h0, pwmOut}, 16'h0000);
    check({15'h0, irq}, 16'h0000);
    check({13'h0, ramp_current_trim}, {13'h0, TRIM_RESET});
    rd(ADDR_SYS_STATUS);
    check(rdVal & 16'h0001, 16'h0001);
    rd(ADDR_SYNC_WIDTH);
    check(rdVal, SYNC_WIDTH_RESET);
    rd(ADDR_MODE_CONTROL);
    check(rdVal, MODE_RESET);
    rd(16'h2080);
    check(rdVal, 16'h0000);
  endtask

  task automatic testControls();
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MODE_CONTROL, 16'(m));
      @(negedge mclk);
      check({14'h0, auxSelect}, 16'(m));
    end
    // A write while the enable is low must not land
    @(posedge mclk);
    clkEn <= 1'b0;
    wr(ADDR_MODE_CONTROL, 16'h0001);
    @(negedge mclk);
    check({14'h0, auxSelect}, 16'h0003);
    @(posedge mclk);
    clkEn <= 1'b1;
    for (int t = 0; t < 8; t++) begin
      wr(ADDR_TRIM, 16'(t));
      @(negedge mclk);
      check({13'h0, ramp_current_trim}, 16'(t));
    end
  endtask

  task automatic testConvert();
    wr(ADDR_SYNC_WIDTH, 16'h0004);
    wr(ADDR_PWM_PERIOD, 16'h00C8);
    for (int i = 0; i < 3; i++) wr(ADDR_DUTY_A + 16'(i), 16'h0032);
    wr(ADDR_MODE_CONTROL, 16'h0080);
    waitSync(w);
    check(16'(w), 16'h0004);
    readRes();
    check(res[1] - res[0], 16'h000A);
    check(res[2] - res[1], 16'h000A);
    check(res[3], RESULT_NONE);
    check(res[0] & 16'hF000, 16'h0000);
    check(16'(res[0] != 16'h0000), 16'h0001);
    wr(ADDR_MODE_CONTROL, 16'h0000);
    readRes();
    check(res[1] - res[0], 16'h0005);
    check(res[2] - res[0], 16'h000A);
  endtask

  task automatic testFault();
    wr(ADDR_IRQ_MASK, 16'h0002);
    wr(ADDR_IRQ_STATUS, 16'h0003);
    waitPwm();
    @(posedge mclk);
    faultActive <= 1'b1;
    #1;
    check({10'h0, pwmOut}, 16'h0000);
    check({15'h0, cycle_sync_pulse}, 16'h0000);
    quiet();
    check({15'h0, irq}, 16'h0001);
    rd(ADDR_SYS_STATUS);
    check(rdVal & 16'h0001, 16'h0000);
    rd(ADDR_IRQ_STATUS);
    check(rdVal & 16'h0002, 16'h0002);
    @(posedge mclk);
    faultActive <= 1'b0;
    restart(16'h0000);
  endtask

  task automatic testSoft();
    waitPwm();
    wr(ADDR_SOFT_SHUTDOWN, 16'h0000);
    @(negedge mclk);
    check({10'h0, pwmOut}, 16'h0000);
    quiet();
    rd(ADDR_IRQ_STATUS);
    check(rdVal & 16'h0002, 16'h0002);
    restart(16'h0001);
  endtask

  initial begin
    fail_count = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    clkEn = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
    faultActive = 1'b0;
    tripDelay = 32'h0028_1E14;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    testReset();
    testControls();
    testConvert();
    testFault();
    testSoft();
    tally_and_finish();
  end

  // Whole sequence needs well under ten thousand cycles
  initial begin
    #(20 * 60000);
    fail_count++;
    tally_and_finish();
  end
endmodule
